//--- blec_pkg.sv
// constants, enums and register layout for the backlight enable and brightness control
// assumes a single 125 MHz clock domain and a decoded register write/read port
`default_nettype none
package blec_pkg;

    // register addresses
    localparam logic [7:0] ADDR_PWM_CTRL = 8'h02;
    localparam logic [7:0] ADDR_BOOST    = 8'h03;
    localparam logic [7:0] ADDR_BRT_LSB  = 8'h04;
    localparam logic [7:0] ADDR_BRT_MSB  = 8'h05;
    localparam logic [7:0] ADDR_ENABLES  = 8'h08;
    localparam logic [7:0] ADDR_FLAGS    = 8'h0F;

    // field positions
    localparam int BIT_PWM_EN     = 0;
    localparam int BIT_PWM_RAMP   = 1;
    localparam int BIT_MAP_LINEAR = 3;
    localparam int BIT_AUTO_FREQ  = 6;
    localparam int BIT_FREQ_SEL   = 7;
    localparam int BIT_BL_EN      = 4;
    localparam int SINK_N         = 2;
    localparam int BRT_W          = 11;
    localparam int BRT_LSB_W      = 3;
    localparam int FLAG_EVT_W     = 6;

    // reset values: linear mapping, full-scale code (30 mA per string)
    localparam logic [7:0]           RST_PWM_CTRL = 8'h08;
    localparam logic [7:0]           RST_BOOST    = 8'h00;
    localparam logic [BRT_LSB_W-1:0] RST_BRT_LSB  = 3'h7;
    localparam logic [BRT_W-1:0]     RST_BRT_CODE = 11'h7FF;
    localparam logic [7:0]           RST_ENABLES  = 8'h00;
    localparam logic [BRT_W-1:0]     DUTY_MAX     = 11'h7FF;

    // duty measurement window and auto-frequency threshold
    localparam int               PWM_CNT_W     = 12;
    localparam logic [11:0]      PWM_WIN_LAST  = 12'h7FF;
    localparam logic [BRT_W-1:0] AUTO_LOW_THR  = 11'h100;
    localparam logic [BRT_W-1:0] RND_HALF      = 11'h400;

    // boost switching frequencies
    localparam int F_HIGH_HZ = 1000000;
    localparam int F_MID_HZ  = 500000;
    localparam int F_LOW_HZ  = 250000;

    typedef enum logic [2:0] {FREQ_1M = 3'h1, FREQ_500K = 3'h2, FREQ_250K = 3'h4} blec_freq_e;
    typedef enum logic [2:0] {ST_SHDN = 3'h1, ST_STBY = 3'h2, ST_ACTV = 3'h4} blec_state_e;

endpackage
`default_nettype wire

//--- blec_duty_if.sv
// carrier for the measured pwm duty between meter and control core
// assumes one clock domain; the meter is the only driver
`timescale 1ns/1ps
`default_nettype none
interface blec_duty_if;
    logic [blec_pkg::BRT_W-1:0] duty;
    logic                       duty_nz;
    logic                       upd;
    modport meter (output duty, output duty_nz, output upd);
    modport user  (input duty, input duty_nz, input upd);
endinterface
`default_nettype wire

//--- blec_pwm_meter.sv
// pwm duty meter: counts high cycles over a fixed 2048-cycle window
// assumes i_pwm already synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module blec_pwm_meter
    import blec_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // pwm input
    input  wire logic        i_enable,
    input  wire logic        i_pwm,
    // measured duty
    blec_duty_if.meter       duty_if
);
    logic [PWM_CNT_W-1:0] win_reg, win_next, high_reg, high_next, total;
    logic [BRT_W-1:0]     duty_reg, duty_next;
    logic                 upd_reg, upd_next;

    // one window, 11-bit result, all-low gives zero
    always_comb
    begin
        total     = high_reg + PWM_CNT_W'(i_pwm);
        win_next  = win_reg + PWM_CNT_W'(1);
        high_next = total;
        duty_next = duty_reg;
        upd_next  = 1'b0;
        if (!i_enable)
        begin
            win_next  = '0;
            high_next = '0;
            duty_next = '0;
        end
        else if (win_reg == PWM_WIN_LAST)
        begin
            win_next  = '0;
            high_next = '0;
            // a full-high window saturates at the top code
            duty_next = (total > PWM_CNT_W'(DUTY_MAX)) ? DUTY_MAX : total[BRT_W-1:0];
            upd_next  = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            win_reg  <= '0;
            high_reg <= '0;
            duty_reg <= '0;
            upd_reg  <= 1'b0;
        end
        else
        begin
            win_reg  <= win_next;
            high_reg <= high_next;
            duty_reg <= duty_next;
            upd_reg  <= upd_next;
        end
    end

    assign duty_if.duty    = duty_reg;
    assign duty_if.duty_nz = (duty_reg != '0);
    assign duty_if.upd     = upd_reg;

    a_low_gives_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_enable && win_reg == PWM_WIN_LAST && total == '0) |=> (duty_reg == '0 && upd_reg))
        else $error("all-low window did not give zero duty");

endmodule // blec_pwm_meter
`default_nettype wire

//--- blec_brt_mult.sv
// brightness multiplier: i2c code times pwm duty, scaled back to 11 bits
// assumes code and duty both full-scale at 11'h7FF
`timescale 1ns/1ps
`default_nettype none
module blec_brt_mult
    import blec_pkg::*;
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // operands
    input  wire logic [BRT_W-1:0] i_code,
    input  wire logic [BRT_W-1:0] i_duty,
    // product
    output logic      [BRT_W-1:0] o_level
);
    logic [2*BRT_W-1:0] prod;
    logic [BRT_W-1:0]   level_next;

    // code times duty, rounded, never zero when both are non-zero
    always_comb
    begin
        prod       = (i_code * i_duty) + (2*BRT_W)'(RND_HALF);
        level_next = prod[2*BRT_W-1:BRT_W];
        if (level_next == '0 && i_code != '0 && i_duty != '0)
        begin
            level_next = BRT_W'(1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_level <= '0;
        end
        else
        begin
            o_level <= level_next;
        end
    end

    a_zero_duty_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_duty == '0) |=> (o_level == '0))
        else $error("zero duty gave non-zero level");

endmodule // blec_brt_mult
`default_nettype wire

//--- blec_backlight_ctrl.sv
// backlight enable and brightness control core: registers, mode state, outputs
// assumes the i2c slave decodes transactions into the write/read strobes below
//
// Functional notes
// - with the master enable input low the block is shut down, registers at default, writes ignored.
// - with the master enable input high the block leaves shutdown and accepts writes.
// - the boost frequency is one of exactly three settings, 1 MHz, 500 kHz and 250 kHz.
// - the frequency comes from the select bit 7 of register 0x03 plus automatic switching.
// - each of the two current sinks has its own enable bit.
// - the backlight turns on only after string setup, a non-zero code and the enable bit 4 of 0x08.
// - reset leaves the enable clear, strings off, pwm off, linear mapping and full-scale code.
// - with pwm on, a non-zero measured duty is multiplied by the code into an 11-bit value.
// - the 11-bit led level comes from the code alone, or from the code times the pwm duty.
// - standby keeps every programmed register.
// - a readable flag register holds sticky fault and warning flags plus status bits.
// - in standby boost and sinks are off yet writes still land; shutdown holds everything in reset.
// - the low three code bits are staged and the level only changes on the high-byte write.
`timescale 1ns/1ps
`default_nettype none
module blec_backlight_ctrl
    import blec_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_master_enable,
    // pwm line
    input  wire logic                  i_pwm,
    // decoded register writes
    input  wire logic                  i_wr_en,
    input  wire logic [7:0]            i_wr_addr,
    input  wire logic [7:0]            i_wr_data,
    // decoded register reads
    input  wire logic                  i_rd_en,
    input  wire logic [7:0]            i_rd_addr,
    output logic      [7:0]            o_rd_data,
    output logic                       o_rd_valid,
    // fault and warning events
    input  wire logic [FLAG_EVT_W-1:0] i_flag_set,
    // power stage control
    output logic                       o_shutdown,
    output logic                       o_standby,
    output logic                       o_boost_en,
    output logic      [SINK_N-1:0]     o_sink_en,
    output logic      [BRT_W-1:0]      o_led_level,
    output logic                       o_linear_map,
    output logic                       o_pwm_ramp,
    output blec_freq_e                 o_boost_freq
);
    // one address decoder serves both the write and read paths
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
        reg_hit = (addr == target);
    endfunction

    logic rst_int_n;
    // master enable low acts as a synchronous reset of everything
    assign rst_int_n = i_rst_n & i_master_enable;

    // programmed registers
    logic [7:0]            pwm_ctrl_reg, pwm_ctrl_next;
    logic [7:0]            boost_reg, boost_next;
    logic [BRT_LSB_W-1:0]  lsb_reg, lsb_next;
    logic [BRT_W-1:0]      code_reg, code_next;
    logic [7:0]            enables_reg, enables_next;
    logic [FLAG_EVT_W-1:0] flag_reg, flag_next;
    logic                  flag_clr;

    // writes land whenever out of reset, in standby too
    always_comb
    begin
        pwm_ctrl_next = pwm_ctrl_reg;
        boost_next    = boost_reg;
        lsb_next      = lsb_reg;
        code_next     = code_reg;
        enables_next  = enables_reg;
        if (i_wr_en)
        begin
            if (reg_hit(i_wr_addr, ADDR_PWM_CTRL))
            begin
                pwm_ctrl_next = i_wr_data;
            end
            if (reg_hit(i_wr_addr, ADDR_BOOST))
            begin
                boost_next = i_wr_data;
            end
            if (reg_hit(i_wr_addr, ADDR_BRT_LSB))
            begin
                lsb_next = i_wr_data[BRT_LSB_W-1:0];
            end
            // high byte commits the full code
            if (reg_hit(i_wr_addr, ADDR_BRT_MSB))
            begin
                code_next = {i_wr_data, lsb_reg};
            end
            if (reg_hit(i_wr_addr, ADDR_ENABLES))
            begin
                enables_next = i_wr_data;
            end
        end
        // read clears the sticky flags, a new event in that cycle survives
        flag_clr  = i_rd_en && reg_hit(i_rd_addr, ADDR_FLAGS);
        flag_next = (flag_clr ? '0 : flag_reg) | i_flag_set;
    end

    // values only change on a write, flags on an event or a flag read, standby included
    always_ff @(posedge i_clk)
    begin
        if (!rst_int_n)
        begin
            pwm_ctrl_reg <= RST_PWM_CTRL;
            boost_reg    <= RST_BOOST;
            lsb_reg      <= RST_BRT_LSB;
            code_reg     <= RST_BRT_CODE;
            enables_reg  <= RST_ENABLES;
            flag_reg     <= '0;
        end
        else
        begin
            pwm_ctrl_reg <= pwm_ctrl_next;
            boost_reg    <= boost_next;
            lsb_reg      <= lsb_next;
            code_reg     <= code_next;
            enables_reg  <= enables_next;
            flag_reg     <= flag_next;
        end
    end

    // duty measurement and brightness product
    blec_duty_if duty_if ();
    logic [BRT_W-1:0] pwm_level;
    logic             pwm_en;
    assign pwm_en = pwm_ctrl_reg[BIT_PWM_EN];

    // duty measured only while pwm is enabled
    blec_pwm_meter u_meter (
        .i_clk    (i_clk),
        .i_rst_n  (rst_int_n),
        .i_enable (pwm_en),
        .i_pwm    (i_pwm),
        .duty_if  (duty_if.meter)
    );

    blec_brt_mult u_mult (
        .i_clk   (i_clk),
        .i_rst_n (rst_int_n),
        .i_code  (code_reg),
        .i_duty  (duty_if.duty),
        .o_level (pwm_level)
    );

    // mode state and outputs
    blec_state_e      state_reg, state_next;
    logic [BRT_W-1:0] level_sel;
    logic             cfg_ok;
    logic             active;
    blec_freq_e       freq_next;
    logic [7:0]       rd_next;

    always_comb
    begin
        // level from code alone or code times duty
        level_sel = pwm_en ? pwm_level : code_reg;
        // enable bit, at least one string and a non-zero code
        // pwm mode also needs a non-zero measured duty
        cfg_ok = enables_reg[BIT_BL_EN] && (enables_reg[SINK_N-1:0] != '0) && (code_reg != '0)
                 && (!pwm_en || duty_if.duty_nz);
        case (state_reg)
            ST_SHDN: state_next = ST_STBY;
            ST_STBY: state_next = cfg_ok ? ST_ACTV : ST_STBY;
            ST_ACTV: state_next = cfg_ok ? ST_ACTV : ST_STBY;
            default: state_next = ST_STBY;
        endcase
        active = (state_next == ST_ACTV);
        // select bit picks high or mid, auto steps down at low levels
        freq_next = boost_reg[BIT_FREQ_SEL] ? FREQ_1M : FREQ_500K;
        if (boost_reg[BIT_AUTO_FREQ] && level_sel < AUTO_LOW_THR)
        begin
            // only the three legal settings are ever produced
            freq_next = boost_reg[BIT_FREQ_SEL] ? FREQ_500K : FREQ_250K;
        end
        rd_next = 8'h00;
        if (reg_hit(i_rd_addr, ADDR_PWM_CTRL))
        begin
            rd_next = pwm_ctrl_reg;
        end
        else if (reg_hit(i_rd_addr, ADDR_BOOST))
        begin
            rd_next = boost_reg;
        end
        else if (reg_hit(i_rd_addr, ADDR_BRT_LSB))
        begin
            rd_next = 8'(lsb_reg);
        end
        else if (reg_hit(i_rd_addr, ADDR_BRT_MSB))
        begin
            rd_next = code_reg[BRT_W-1:BRT_LSB_W];
        end
        else if (reg_hit(i_rd_addr, ADDR_ENABLES))
        begin
            rd_next = enables_reg;
        end
        // status bits on top of the sticky flags
        else if (reg_hit(i_rd_addr, ADDR_FLAGS))
        begin
            rd_next = {state_reg == ST_ACTV, duty_if.duty_nz, flag_reg};
        end
    end

    // shutdown and standby force boost and sinks off
    // each sink follows its own enable bit
    always_ff @(posedge i_clk)
    begin
        if (!rst_int_n)
        begin
            state_reg    <= ST_SHDN;
            o_shutdown   <= 1'b1;
            o_standby    <= 1'b0;
            o_boost_en   <= 1'b0;
            o_sink_en    <= '0;
            o_led_level  <= '0;
            o_linear_map <= RST_PWM_CTRL[BIT_MAP_LINEAR];
            o_pwm_ramp   <= RST_PWM_CTRL[BIT_PWM_RAMP];
            o_boost_freq <= FREQ_500K;
            o_rd_data    <= 8'h00;
            o_rd_valid   <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            o_shutdown   <= (state_next == ST_SHDN);
            o_standby    <= (state_next == ST_STBY);
            o_boost_en   <= active;
            o_sink_en    <= active ? enables_reg[SINK_N-1:0] : '0;
            o_led_level  <= active ? level_sel : '0;
            o_linear_map <= pwm_ctrl_reg[BIT_MAP_LINEAR];
            o_pwm_ramp   <= pwm_ctrl_reg[BIT_PWM_RAMP];
            o_boost_freq <= freq_next;
            o_rd_data    <= i_rd_en ? rd_next : 8'h00;
            o_rd_valid   <= i_rd_en;
        end
    end

    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_int_n);

    a_shdn_forces_off: assert property (disable iff (!i_rst_n)
        !i_master_enable |=> (o_shutdown && !o_boost_en && o_sink_en == '0 && code_reg == RST_BRT_CODE))
        else $error("master enable low did not shut down");
    a_enable_leaves_shdn: assert property (disable iff (1'b0)
        (i_rst_n && i_master_enable && o_shutdown) |=> (!o_shutdown && o_standby))
        else $error("enable high did not leave shutdown");
    a_freq_three_only: assert property (
        o_boost_freq inside {FREQ_1M, FREQ_500K, FREQ_250K})
        else $error("illegal boost frequency");
    a_freq_sel_bit: assert property (
        (!boost_reg[BIT_AUTO_FREQ]) |=> (o_boost_freq == ($past(boost_reg[BIT_FREQ_SEL]) ? FREQ_1M : FREQ_500K)))
        else $error("frequency select not followed");
    a_sink_enables: assert property (
        (state_next == ST_ACTV) |=> (o_sink_en == $past(enables_reg[SINK_N-1:0])))
        else $error("sink enable mismatch");
    a_on_needs_setup: assert property (
        $rose(o_boost_en) |-> $past(enables_reg[BIT_BL_EN] && enables_reg[SINK_N-1:0] != '0 && code_reg != '0))
        else $error("backlight on without setup");
    a_reset_defaults: assert property (disable iff (!i_rst_n)
        $rose(i_master_enable) |-> (enables_reg == RST_ENABLES && pwm_ctrl_reg == RST_PWM_CTRL
                                    && code_reg == RST_BRT_CODE))
        else $error("defaults wrong after reset");
    a_zero_duty_stby: assert property (
        (pwm_en && !duty_if.duty_nz) |=> !o_boost_en)
        else $error("boost on with zero pwm duty");
    a_stby_retains: assert property (
        (state_reg == ST_STBY && !i_wr_en) |=> $stable(enables_reg) && $stable(code_reg) && $stable(boost_reg))
        else $error("register changed in standby without a write");
    a_flag_set_wins: assert property (
        (i_flag_set != '0) |=> ((flag_reg & $past(i_flag_set)) == $past(i_flag_set)))
        else $error("flag event lost");
    a_stby_outputs_off: assert property (
        (state_reg != ST_ACTV) |-> (!o_boost_en && o_sink_en == '0 && o_led_level == '0))
        else $error("outputs on outside active state");
    a_lsb_no_update: assert property (
        (i_wr_en && reg_hit(i_wr_addr, ADDR_BRT_LSB)) |=> $stable(code_reg))
        else $error("low-bit write changed the level");
    a_duty_upd_pwm: assert property (
        duty_if.upd |-> $past(pwm_en))
        else $error("duty updated while pwm disabled");

endmodule // blec_backlight_ctrl
`default_nettype wire

//--- blec_host_model.sv
// host side model: decoded register writes and reads, plus the pwm line
// assumes the bench calls wr/rd and sets pwm_high; one clock domain
`timescale 1ns/1ps
`default_nettype none
module blec_host_model
(
    // clock
    input  wire logic       i_clk,
    // register access
    output logic            o_wr_en,
    output logic [7:0]      o_wr_addr,
    output logic [7:0]      o_wr_data,
    output logic            o_rd_en,
    output logic [7:0]      o_rd_addr,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid,
    // pwm line
    output logic            o_pwm
);
    int pwm_high = 0;
    int pwm_ph   = 0;

    initial
    begin
        o_wr_en   = 1'b0;
        o_wr_addr = 8'h00;
        o_wr_data = 8'h00;
        o_rd_en   = 1'b0;
        o_rd_addr = 8'h00;
        o_pwm     = 1'b0;
    end

    // period of 2048 cycles, all low at zero
    // any 2048-cycle window then holds exactly pwm_high high cycles
    always @(posedge i_clk)
    begin
        pwm_ph <= (pwm_ph + 1) % 2048;
        o_pwm  <= #1 (pwm_ph < pwm_high);
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_wr_en   = 1'b1;
        o_wr_addr = a;
        o_wr_data = d;
        @(posedge i_clk);
        #1;
        o_wr_en   = 1'b0;
        // released lines show the inverse, not a stale value
        o_wr_addr = ~a;
        o_wr_data = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk);
        #1;
        o_rd_en   = 1'b1;
        o_rd_addr = a;
        @(posedge i_clk);
        #1;
        o_rd_en   = 1'b0;
        o_rd_addr = ~a;
        d         = i_rd_data;
        v         = i_rd_valid;
    endtask
endmodule // blec_host_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the backlight enable and brightness control
// assumes the host model drives the register port and the pwm line
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import blec_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        men;
    logic        pwm;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic [5:0]  flag_set;
    logic        shdn;
    logic        stby;
    logic        boost_en;
    logic [1:0]  sink_en;
    logic [10:0] level;
    logic        lin_map;
    logic        ramp;
    blec_freq_e  bfreq;
    logic [7:0]  rdat;
    logic        rv;
    int          err_total    = 0;
    int          total_checks = 0;
    logic [7:0]  ra [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0F, 8'h7E};
    logic [7:0]  re [7] = '{8'h08, 8'h00, 8'h07, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [7:0]  fm [5] = '{8'h40, 8'h40, 8'h40, 8'h10, 8'h10};
    logic [7:0]  fb [5] = '{8'h80, 8'h00, 8'hC0, 8'h40, 8'hC0};
    blec_freq_e  fx [5] = '{FREQ_1M, FREQ_500K, FREQ_1M, FREQ_250K, FREQ_500K};

    blec_host_model host_i (.i_clk(clk), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
        .o_wr_data(wr_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr),
        .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_pwm(pwm));

    blec_backlight_ctrl blec_backlight_ctrl_i (.i_clk(clk), .i_rst_n(rst_n),
        .i_master_enable(men), .i_pwm(pwm), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
        .i_wr_data(wr_data), .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .i_flag_set(flag_set), .o_shutdown(shdn), .o_standby(stby),
        .o_boost_en(boost_en), .o_sink_en(sink_en), .o_led_level(level),
        .o_linear_map(lin_map), .o_pwm_ramp(ramp), .o_boost_freq(bfreq));

    task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host_i.rd(a, rdat, rv);
        chk("rd_valid", 11'(rv), 11'h001);
        chk($sformatf("reg_%h", a), 11'(rdat), 11'(exp));
    endtask

    task automatic outs(input logic [10:0] lv, input logic [1:0] sk, input logic sb, input logic be);
        chk("led_level", level, lv);
        chk("sink_en", 11'(sink_en), 11'(sk));
        chk("standby", 11'(stby), 11'(sb));
        chk("boost_en", 11'(boost_en), 11'(be));
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // tests need about 20000 cycles
    initial
    begin
        #(40000 * 8);
        err_total++;
        report_and_stop();
    end

    initial
    begin
        rst_n    = 1'b0;
        men      = 1'b1;
        flag_set = 6'h00;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        settle(4);
        chk("shutdown", 11'(shdn), 11'h000);
        outs(11'h000, 2'h0, 1'b1, 1'b0);
        chk("lin_map", 11'(lin_map), 11'h001);
        chk("ramp", 11'(ramp), 11'h000);
        chk("freq", 11'(bfreq), 11'(FREQ_500K));
        for (int i = 0; i < 7; i++)
            rchk(ra[i], re[i]);
        // strings first, then the enable bit
        host_i.wr(8'h08, 8'h03);
        host_i.wr(8'h08, 8'h13);
        settle(4);
        outs(11'h7FF, 2'h3, 1'b0, 1'b1);
        for (int s = 2; s >= 0; s--)
        begin
            host_i.wr(8'h08, 8'h10 | 8'(s));
            settle(4);
            outs((s != 0) ? 11'h7FF : 11'h000, 2'(s), s == 0, s != 0);
        end
        host_i.wr(8'h05, 8'h20);
        host_i.wr(8'h08, 8'h13);
        men = 1'b0;
        settle(4);
        chk("shutdown", 11'(shdn), 11'h001);
        outs(11'h000, 2'h0, 1'b0, 1'b0);
        host_i.wr(8'h08, 8'h13);
        host_i.rd(8'h08, rdat, rv);
        chk("rd_valid", 11'(rv), 11'h000);
        men = 1'b1;
        host_i.wr(8'h04, 8'h05);
        rchk(8'h04, 8'h05);
        rchk(8'h05, 8'hFF);
        rchk(8'h08, 8'h00);
        // staged low bits alone leave the level alone
        host_i.wr(8'h08, 8'h13);
        settle(4);
        outs(11'h7FF, 2'h3, 1'b0, 1'b1);
        host_i.wr(8'h05, 8'h12);
        settle(4);
        outs(11'h095, 2'h3, 1'b0, 1'b1);
        host_i.wr(8'h04, 8'h00);
        host_i.wr(8'h05, 8'h00);
        settle(4);
        outs(11'h000, 2'h0, 1'b1, 1'b0);
        host_i.wr(8'h04, 8'h01);
        host_i.wr(8'h05, 8'h40);
        host_i.wr(8'h08, 8'h03);
        settle(4);
        outs(11'h000, 2'h0, 1'b1, 1'b0);
        rchk(8'h05, 8'h40);
        rchk(8'h08, 8'h03);
        host_i.wr(8'h08, 8'h13);
        settle(4);
        outs(11'h201, 2'h3, 1'b0, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            host_i.wr(8'h05, fm[i]);
            host_i.wr(8'h03, fb[i]);
            settle(4);
            chk("freq", 11'(bfreq), 11'(fx[i]));
        end
        // pwm mode waits three full duty windows
        host_i.wr(8'h04, 8'h00);
        host_i.wr(8'h05, 8'h80);
        host_i.wr(8'h02, 8'h09);
        settle(6200);
        outs(11'h000, 2'h0, 1'b1, 1'b0);
        rchk(8'h0F, 8'h00);
        host_i.pwm_high = 1024;
        settle(6200);
        outs(11'h200, 2'h3, 1'b0, 1'b1);
        host_i.wr(8'h04, 8'h01);
        host_i.wr(8'h05, 8'h00);
        host_i.pwm_high = 1;
        settle(6200);
        outs(11'h001, 2'h3, 1'b0, 1'b1);
        @(posedge clk);
        #1;
        flag_set = 6'h2A;
        @(posedge clk);
        #1;
        flag_set = 6'h00;
        rchk(8'h0F, 8'hEA);
        rchk(8'h0F, 8'hC0);
        host_i.wr(8'h02, 8'h02);
        settle(4);
        chk("lin_map", 11'(lin_map), 11'h000);
        chk("ramp", 11'(ramp), 11'h001);
        outs(11'h001, 2'h3, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
